// [hdl/mps_pkg.sv]
`default_nettype none
package mps_pkg;
   // ==========================================================
   // Widths
   localparam int MPS_ADDR_W      = 12;
   localparam int MPS_DATA_W      = 16;
   localparam int MPS_TAG_W       = 5;
   localparam int MPS_STACK_DEPTH = 8;
   localparam int MPS_CON_W       = 10;
   localparam int MPS_IO_W        = 8;
   localparam int MPS_MODE_W      = 10;
   localparam int MPS_BUS_AW      = 4;
   localparam int MPS_EXT_CC_N    = 8;

   // ==========================================================
   // Program addresses
   localparam logic [MPS_ADDR_W-1:0] MPS_ORIGIN   = 12'h000;
   localparam logic [MPS_ADDR_W-1:0] MPS_VEC_INT0 = 12'h008;
   localparam logic [MPS_ADDR_W-1:0] MPS_VEC_INT7 = 12'h00f;

   // ==========================================================
   // Register fields and reset values
   localparam int MPS_CON_ADDRESS_COUNTER_ENABLE      = 0;
   localparam int MPS_CON_BLOCK_COUNTER_ENABLE      = 1;
   localparam int MPS_MODE_INTERRUPT_MODE     = 0;
   localparam int MPS_MODE_FIFO_RST = 9;
   localparam logic [MPS_CON_W-1:0]  MPS_CON_RST  = 10'h000;
   localparam logic [MPS_IO_W-1:0]   MPS_IO_RST   = 8'h00;
   localparam logic [MPS_MODE_W-1:0] MPS_MODE_RST = 10'h000;

   // ==========================================================
   // Register port offsets
   localparam logic [MPS_BUS_AW-1:0] MPS_OFS_CON  = 4'h0;
   localparam logic [MPS_BUS_AW-1:0] MPS_OFS_IO   = 4'h1;
   localparam logic [MPS_BUS_AW-1:0] MPS_OFS_MODE = 4'h2;
   localparam logic [MPS_BUS_AW-1:0] MPS_OFS_STAT = 4'h3;

   // ==========================================================
   // Instructions and condition codes
   typedef enum logic [4:0] {
      OP_NOP     = 5'h00, OP_JMP     = 5'h01, OP_CALL    = 5'h02,
      OP_LDLC    = 5'h03, OP_LOOP_END_BRANCH  = 5'h04, OP_PUSH_LOOP_COUNT  = 5'h05,
      OP_POP_LOOP_COUNT   = 5'h06, OP_POP     = 5'h07, OP_RC      = 5'h08,
      OP_RNC     = 5'h09, OP_RET     = 5'h0a, OP_RESTART = 5'h0b,
      OP_FIFO_TO_REGISTER_MOVE  = 5'h0c, OP_CONTROL_SET  = 5'h0d, OP_CONTROL_CLEAR  = 5'h0e,
      OP_SETIO   = 5'h0f, OP_IO_DIRECTION_CLEAR   = 5'h10, OP_SETMODE = 5'h11,
      OP_MODE_CLEAR = 5'h12, OP_SBC     = 5'h13
   } mps_op_t;

   typedef enum logic [4:0] {
      CC_INTERRUPT_MODE = 5'h00, CC_BCZ  = 5'h01, CC_FIFO_OUTPUT_FLAG = 5'h02, CC_FIFO_COMMAND_FLAG = 5'h03,
      CC_Z    = 5'h04, CC_O    = 5'h05, CC_S    = 5'h06, CC_CY   = 5'h07,
      CC_ACO  = 5'h08, CC_FIFO_EXCEPTION_FLAG = 5'h09, CC_FIFO_INPUT_FLAG = 5'h0a, CC_STACK_FULL_FLAG = 5'h0b,
      CC_DOR  = 5'h0c, CC_EXT0 = 5'h0d
   } mps_cc_t;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic                  valid;
      mps_op_t               op;
      mps_cc_t               cc;
      logic                  has_target;
      logic [MPS_ADDR_W-1:0] target;
      logic [MPS_CON_W-1:0]  mask;
      logic [MPS_TAG_W-1:0]  dest;
      logic [MPS_DATA_W-1:0] src1;
      logic [MPS_DATA_W-1:0] src2;
   } mps_instr_t;

   typedef struct packed {
      logic [MPS_DATA_W-1:0] data;
      logic [MPS_TAG_W-1:0]  tag;
      logic                  is_cmd;
      logic                  empty;
      logic                  full;
   } mps_fifo_head_t;

   typedef struct packed {
      logic carry;
      logic zero;
      logic sign;
      logic ovf;
      logic address_counter_ones_flag;
      logic block_count_zero_flag;
      logic fifo_input_flag;
      logic fifo_output_flag;
      logic fifo_exception_flag;
      logic fifo_command_flag;
      logic data_out_flag;
   } mps_flags_t;

   typedef struct packed {
      logic                  wr;
      logic [MPS_TAG_W-1:0]  addr;
      logic [MPS_DATA_W-1:0] data;
   } mps_rf_wr_t;
endpackage
`default_nettype wire

// [hdl/mps_seq_ctrl.sv]
// Functional notes
// RULE_01 - Pop loop count restores it, updates full
// RULE_02 - Push loop count keeps counter, updates full
// RULE_03 - Return-if-true loads address from stack top
// RULE_04 - Return-if-true with target branches, always pops
// RULE_05 - Return-if-false returns only on false condition
// RULE_06 - Return-if-false with target branches, pops
// RULE_07 - Subroutine exit pops stack into next address
// RULE_08 - Exit with target jumps there, still pops
// RULE_09 - Jump-to-origin goes to location zero
// RULE_10 - Jump-to-origin initialises only stack pointer
// RULE_11 - Jump-to-origin clears listed arithmetic and status flags
// RULE_12 - FIFO read writes head into tagged register
// RULE_13 - Empty FIFO read repeats previous head value
// RULE_14 - Command head raises exception, updates flags
// RULE_15 - Control clear drops masked bits only
// RULE_16 - Address counter enable bit0, block bit1
// RULE_17 - I/O clear drops masked direction bits
// RULE_18 - Mode clear drops masked bits only
// RULE_19 - Mode bit 9 holds FIFO in reset
// RULE_20 - External interrupt 0 vectors to 8h
// RULE_21 - Interrupt 7 vectors to Fh, internal causes
// RULE_22 - Subtract with borrow when carry is clear
// RULE_23 - Loop end tests count before decrementing
// RULE_24 - Control set raises masked bits only
`timescale 1ns/100ps
`default_nettype none
module mps_seq_ctrl
   import mps_pkg::*;
#(
   parameter int STACK_DEPTH = MPS_STACK_DEPTH
) (
   // Clock and reset
   input  wire logic                    clk_sys_i,
   input  wire logic                    nrst_i,
   input  wire logic                    ce_i,
   // Instruction stream
   input  wire mps_instr_t              ins_i,
   input  wire logic [MPS_EXT_CC_N-1:0] ext_cc_i,
   output logic [MPS_ADDR_W-1:0]        pc_o,
   // FIFO head and CPU register write
   input  wire mps_fifo_head_t          fifo_i,
   output logic                         fifo_pop_o,
   output logic                         fifo_reset_o,
   output mps_rf_wr_t                   rf_o,
   // Events and interrupts
   input  wire logic                    irq0_i,
   input  wire logic                    irq7_i,
   input  wire logic                    aco_evt_i,
   input  wire logic                    bcz_evt_i,
   input  wire logic                    dor_evt_i,
   // Status
   output mps_flags_t                   flags_o,
   output logic                         stack_full_o,
   output logic [MPS_ADDR_W-1:0]        loop_count_o,
   output logic [MPS_CON_W-1:0]         control_o,
   output logic [MPS_IO_W-1:0]          io_dir_o,
   output logic [MPS_MODE_W-1:0]        mode_o,
   // Register port
   input  wire logic [MPS_BUS_AW-1:0]   bus_addr_i,
   input  wire logic [MPS_DATA_W-1:0]   bus_wdata_i,
   input  wire logic                    bus_wr_i,
   input  wire logic                    bus_rd_i,
   output logic [MPS_DATA_W-1:0]        bus_rdata_o
);
   localparam int SP_W = $clog2(STACK_DEPTH + 1);
   localparam int AW   = MPS_ADDR_W;
   localparam int DW   = MPS_DATA_W;
   typedef struct packed {
      logic [AW-1:0]                  pc;
      logic [AW-1:0]                  lc;
      logic [STACK_DEPTH-1:0][AW-1:0] stk;
      logic [SP_W-1:0]                sp;
      mps_flags_t                     fl;
      logic [MPS_CON_W-1:0]           con;
      logic [MPS_IO_W-1:0]            io;
      logic [MPS_MODE_W-1:0]          mode;
      logic [DW-1:0]                  head;
      logic [MPS_TAG_W-1:0]           head_tag;
      logic                           pend0;
      logic                           pend7;
      logic                           int7_prev;
      mps_rf_wr_t                     rf;
      logic [DW-1:0]                  rdata;
   } mps_state_t;
   mps_state_t      st_q;
   mps_state_t      st_d;
   logic            stack_full_flag, sp_empty, take, exec, cond, int7_src, is_cmd;
   logic [SP_W-1:0] top_idx;
   logic [AW-1:0]   top;
   logic [AW-1:0]   pc_inc;
   logic [DW:0]     diff;

   // ==========================================================
   // Condition code selection
   function automatic logic cc_eval(input mps_cc_t sel, input mps_flags_t f,
                                    input logic sf, input logic interrupt_mode,
                                    input logic [MPS_EXT_CC_N-1:0] ext);
      logic [4:0] n;
      n = 5'(sel) - 5'(CC_EXT0);
      case (sel)
         CC_INTERRUPT_MODE: cc_eval = interrupt_mode;
         CC_BCZ:  cc_eval = f.block_count_zero_flag;
         CC_FIFO_OUTPUT_FLAG: cc_eval = f.fifo_output_flag;
         CC_FIFO_COMMAND_FLAG: cc_eval = f.fifo_command_flag;
         CC_Z:    cc_eval = f.zero;
         CC_O:    cc_eval = f.ovf;
         CC_S:    cc_eval = f.sign;
         CC_CY:   cc_eval = f.carry;
         CC_ACO:  cc_eval = f.address_counter_ones_flag;
         CC_FIFO_EXCEPTION_FLAG: cc_eval = f.fifo_exception_flag;
         CC_FIFO_INPUT_FLAG: cc_eval = f.fifo_input_flag;
         CC_STACK_FULL_FLAG: cc_eval = sf;
         CC_DOR:  cc_eval = f.data_out_flag;
         default: cc_eval = (n < 5'(MPS_EXT_CC_N)) ? ext[n[2:0]] : 1'b0;
      endcase
   endfunction

   // ==========================================================
   // Shared terms
   assign stack_full_flag     = (st_q.sp == SP_W'(STACK_DEPTH));
   assign sp_empty = (st_q.sp == '0);
   assign top_idx  = sp_empty ? '0 : st_q.sp - SP_W'(1);
   assign top      = st_q.stk[top_idx];
   assign pc_inc   = st_q.pc + AW'(1);
   // Interrupt 7 is raised by a rising internal cause
   assign int7_src = st_q.fl.address_counter_ones_flag | stack_full_flag; // RULE_21
   assign take     = ins_i.valid & st_q.mode[MPS_MODE_INTERRUPT_MODE] & (st_q.pend0 | st_q.pend7);
   assign exec     = ins_i.valid & ~take;
   assign cond     = cc_eval(ins_i.cc, st_q.fl, stack_full_flag, st_q.mode[MPS_MODE_INTERRUPT_MODE], ext_cc_i);
   assign is_cmd   = fifo_i.is_cmd & ~fifo_i.empty;
   // Borrow in is the inverse of carry
   assign diff = {1'b0, ins_i.src1} - {1'b0, ins_i.src2} - {{DW{1'b0}}, ~st_q.fl.carry}; // RULE_22
   // A command head stays in the FIFO for the exception handler
   assign fifo_pop_o = ce_i & exec & (ins_i.op == OP_FIFO_TO_REGISTER_MOVE) & ~fifo_i.empty & ~fifo_i.is_cmd;

   // ==========================================================
   // Next state
   always_comb begin
      logic                 do_push, do_pop;
      logic [AW-1:0]        push_val;
      logic [DW-1:0]        rd_val;
      logic [MPS_TAG_W-1:0] rd_tag;
      do_push  = 1'b0;
      do_pop   = 1'b0;
      push_val = pc_inc;
      rd_val   = fifo_i.empty ? st_q.head : fifo_i.data; // RULE_13
      rd_tag   = fifo_i.empty ? st_q.head_tag : fifo_i.tag;
      st_d           = st_q;
      st_d.rf.wr     = 1'b0;
      st_d.rdata     = '0;
      st_d.int7_prev = int7_src;

      if (bus_wr_i) begin
         case (bus_addr_i)
            MPS_OFS_CON:  st_d.con  = bus_wdata_i[MPS_CON_W-1:0];
            MPS_OFS_IO:   st_d.io   = bus_wdata_i[MPS_IO_W-1:0];
            MPS_OFS_MODE: st_d.mode = bus_wdata_i[MPS_MODE_W-1:0];
            default: ;
         endcase
      end
      if (bus_rd_i) begin
         case (bus_addr_i)
            MPS_OFS_CON:  st_d.rdata = DW'(st_q.con);
            MPS_OFS_IO:   st_d.rdata = DW'(st_q.io);
            MPS_OFS_MODE: st_d.rdata = DW'(st_q.mode);
            MPS_OFS_STAT: st_d.rdata = DW'({stack_full_flag, st_q.fl});
            default:      st_d.rdata = '0;
         endcase
      end

      if (take) begin
         // The pending instruction is replayed on return
         do_push  = 1'b1;
         push_val = st_q.pc;
         if (st_q.pend0) begin
            st_d.pc    = MPS_VEC_INT0; // RULE_20
            st_d.pend0 = 1'b0;
         end else begin
            st_d.pc    = MPS_VEC_INT7; // RULE_21
            st_d.pend7 = 1'b0;
         end
      end else if (ins_i.valid) begin
         st_d.pc = pc_inc;
         case (ins_i.op)
            OP_JMP: st_d.pc = ins_i.target;
            OP_CALL: begin
               do_push = 1'b1;
               st_d.pc = ins_i.target;
            end
            OP_LDLC: st_d.lc = ins_i.target;
            OP_LOOP_END_BRANCH: if (st_q.lc != '0) begin // RULE_23
               st_d.lc = st_q.lc - AW'(1);
               st_d.pc = ins_i.target;
            end
            OP_PUSH_LOOP_COUNT: begin
               do_push  = 1'b1; // RULE_02
               push_val = st_q.lc;
            end
            OP_POP_LOOP_COUNT: begin
               do_pop  = 1'b1; // RULE_01
               st_d.lc = top;
            end
            OP_POP: do_pop = 1'b1;
            OP_RC: begin
               if (cond) st_d.pc = ins_i.has_target ? ins_i.target : top; // RULE_03
               do_pop = cond | ins_i.has_target; // RULE_04
            end
            OP_RNC: if (!cond) begin
               st_d.pc = ins_i.has_target ? ins_i.target : top; // RULE_05
               do_pop  = 1'b1; // RULE_06
            end
            OP_RET: begin
               st_d.pc = ins_i.has_target ? ins_i.target : top; // RULE_07
               do_pop  = 1'b1; // RULE_08
            end
            OP_RESTART: begin
               st_d.pc = MPS_ORIGIN; // RULE_09
               st_d.sp = '0; // RULE_10
               st_d.fl.carry                     = 1'b0; // RULE_11
               st_d.fl.zero                      = 1'b0;
               st_d.fl.sign                      = 1'b0;
               st_d.fl.address_counter_ones_flag = 1'b0;
               st_d.fl.block_count_zero_flag     = 1'b0;
               st_d.fl.fifo_input_flag           = 1'b0;
               st_d.fl.fifo_output_flag          = 1'b0;
               st_d.fl.fifo_exception_flag       = 1'b0;
               st_d.fl.data_out_flag             = 1'b0;
            end
            OP_FIFO_TO_REGISTER_MOVE: begin
               st_d.fl.fifo_command_flag   = is_cmd;
               st_d.fl.fifo_exception_flag = is_cmd; // RULE_14
               st_d.fl.fifo_input_flag     = ~fifo_i.empty;
               st_d.fl.fifo_output_flag    = ~fifo_i.full;
               st_d.fl.carry               = 1'b0;
               st_d.fl.ovf                 = 1'b0;
               if (!is_cmd) begin
                  st_d.head     = rd_val;
                  st_d.head_tag = rd_tag;
                  st_d.rf.wr    = 1'b1; // RULE_12
                  st_d.rf.addr  = rd_tag;
                  st_d.rf.data  = rd_val;
                  st_d.fl.zero  = (rd_val == '0);
                  st_d.fl.sign  = rd_val[DW-1];
               end
            end
            OP_CONTROL_SET:  st_d.con  = st_q.con | ins_i.mask; // RULE_24
            OP_CONTROL_CLEAR:  st_d.con  = st_q.con & ~ins_i.mask; // RULE_15
            OP_SETIO:   st_d.io   = st_q.io | ins_i.mask[MPS_IO_W-1:0];
            OP_IO_DIRECTION_CLEAR:   st_d.io   = st_q.io & ~ins_i.mask[MPS_IO_W-1:0]; // RULE_17
            OP_SETMODE: st_d.mode = st_q.mode | ins_i.mask;
            OP_MODE_CLEAR: st_d.mode = st_q.mode & ~ins_i.mask; // RULE_18
            OP_SBC: begin
               st_d.rf.wr    = 1'b1; // RULE_22
               st_d.rf.addr  = ins_i.dest;
               st_d.rf.data  = diff[DW-1:0];
               st_d.fl.carry = ~diff[DW];
               st_d.fl.zero  = (diff[DW-1:0] == '0);
               st_d.fl.sign  = diff[DW-1];
               st_d.fl.ovf   = (ins_i.src1[DW-1] ^ ins_i.src2[DW-1])
                             & (ins_i.src1[DW-1] ^ diff[DW-1]);
            end
            default: ;
         endcase
      end

      // A full stack drops the push; an empty one ignores the pop
      if (do_pop && !sp_empty) st_d.sp = st_q.sp - SP_W'(1);
      else if (do_push && !stack_full_flag) begin
         st_d.stk[top_idx + SP_W'(!sp_empty)] = push_val;
         st_d.sp = st_q.sp + SP_W'(1);
      end

      // Events arriving with a clear still stick
      if (irq0_i) st_d.pend0 = 1'b1;
      if (irq7_i || (int7_src && !st_q.int7_prev)) st_d.pend7 = 1'b1;
      if (aco_evt_i) st_d.fl.address_counter_ones_flag = 1'b1;
      if (bcz_evt_i) st_d.fl.block_count_zero_flag = 1'b1;
      if (dor_evt_i) st_d.fl.data_out_flag = 1'b1;
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q      <= '0;
         st_q.pc   <= MPS_ORIGIN;
         st_q.con  <= MPS_CON_RST;
         st_q.io   <= MPS_IO_RST;
         st_q.mode <= MPS_MODE_RST;
      end else if (ce_i) begin
         st_q <= st_d;
      end
   end

   // ==========================================================
   // Outputs
   assign pc_o         = st_q.pc;
   assign rf_o         = st_q.rf;
   assign flags_o      = st_q.fl;
   assign stack_full_o = stack_full_flag;
   assign loop_count_o = st_q.lc;
   assign control_o    = st_q.con;
   assign io_dir_o     = st_q.io;
   assign mode_o       = st_q.mode;
   assign fifo_reset_o = st_q.mode[MPS_MODE_FIFO_RST]; // RULE_19
   assign bus_rdata_o  = st_q.rdata;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   sequence s_do(mps_op_t o);
      ce_i && exec && !bus_wr_i && ins_i.op == o;
   endsequence

   push_keeps_a: assert property (s_do(OP_PUSH_LOOP_COUNT) ##0 !stack_full_flag |=> // RULE_02
      top == $past(st_q.lc) && st_q.lc == $past(st_q.lc) && st_q.sp == $past(st_q.sp) + SP_W'(1))
      else $error("push loop count wrong");
   pop_restores_a: assert property (s_do(OP_POP_LOOP_COUNT) ##0 !sp_empty |=> // RULE_01
      st_q.lc == $past(top) && st_q.sp == $past(st_q.sp) - SP_W'(1))
      else $error("pop loop count wrong");
   rc_plain_a: assert property (s_do(OP_RC) ##0 cond && !ins_i.has_target && !sp_empty // RULE_03
      |=> st_q.pc == $past(top))
      else $error("conditional return address wrong");
   rc_target_a: assert property (s_do(OP_RC) ##0 ins_i.has_target && !sp_empty // RULE_04
      |=> st_q.sp == $past(st_q.sp) - SP_W'(1))
      else $error("conditional return did not pop");
   rnc_true_a: assert property (s_do(OP_RNC) ##0 cond |=> $stable(st_q.sp) // RULE_05
      && st_q.pc == $past(pc_inc))
      else $error("false-return acted on true");
   rnc_target_a: assert property (s_do(OP_RNC) ##0 !cond && ins_i.has_target && !sp_empty // RULE_06
      |=> st_q.pc == $past(ins_i.target) && st_q.sp == $past(st_q.sp) - SP_W'(1))
      else $error("false-return branch wrong");
   ret_target_a: assert property (s_do(OP_RET) ##0 ins_i.has_target && !sp_empty // RULE_08
      |=> st_q.pc == $past(ins_i.target) && st_q.sp == $past(st_q.sp) - SP_W'(1))
      else $error("exit with target wrong");
   restart_a: assert property (s_do(OP_RESTART) |=> st_q.pc == MPS_ORIGIN // RULE_10
      && st_q.sp == '0 && st_q.lc == $past(st_q.lc) && st_q.con == $past(st_q.con))
      else $error("origin jump initialised too much");
   control_clear_a: assert property (s_do(OP_CONTROL_CLEAR) |=> // RULE_15
      st_q.con == ($past(st_q.con) & ~$past(ins_i.mask)))
      else $error("control clear wrong");
   fifo_again_a: assert property (s_do(OP_FIFO_TO_REGISTER_MOVE) ##0 fifo_i.empty |=> // RULE_13
      rf_o.wr && rf_o.data == $past(st_q.head))
      else $error("empty read did not repeat head");
   fifo_cmd_a: assert property (s_do(OP_FIFO_TO_REGISTER_MOVE) ##0 is_cmd |-> !fifo_pop_o // RULE_14
      ##1 st_q.fl.fifo_exception_flag && !rf_o.wr)
      else $error("command head not flagged");
   vec0_a: assert property (ce_i && take && st_q.pend0 |=> st_q.pc == MPS_VEC_INT0) // RULE_20
      else $error("interrupt 0 vector wrong");
   sbc_a: assert property (s_do(OP_SBC) |=> rf_o.wr && rf_o.data == // RULE_22
      $past(ins_i.src1) - $past(ins_i.src2) - DW'(!$past(st_q.fl.carry)))
      else $error("subtract with borrow wrong");
   loop_a: assert property (s_do(OP_LOOP_END_BRANCH) ##0 st_q.lc == '0 |=> // RULE_23
      st_q.pc == $past(pc_inc) && st_q.lc == '0)
      else $error("loop end at zero count wrong");
   con_bits_a: assert property (s_do(OP_CONTROL_CLEAR) ##0 ins_i.mask[MPS_CON_ADDRESS_COUNTER_ENABLE] && ins_i.mask[MPS_CON_BLOCK_COUNTER_ENABLE] // RULE_16
      |=> !st_q.con[MPS_CON_ADDRESS_COUNTER_ENABLE] && !st_q.con[MPS_CON_BLOCK_COUNTER_ENABLE])
      else $error("counter enable bits not cleared");
   sequence s_rst_set;
      s_do(OP_SETMODE) ##0 ins_i.mask[MPS_MODE_FIFO_RST];
   endsequence
   sequence s_rst_held;
      fifo_reset_o [*2];
   endsequence
   fifo_rst_a: assert property (s_rst_set ##1 !ce_i |-> s_rst_held) // RULE_19
      else $error("fifo reset not held");
endmodule
`default_nettype wire

// [tb/tb_mps_seq_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_mps_seq_ctrl import mps_pkg::*;;
   typedef struct packed {mps_op_t op; logic [9:0] mask; logic [1:0] sel; logic [9:0] exp;} mps_row_t;
   logic clk_sys_i, nrst_i, ce_i, fifo_pop_o, fifo_reset_o, irq0_i, irq7_i, dor_evt_i, stack_full_o;
   logic bus_wr_i, bus_rd_i;
   mps_instr_t ins_i;
   mps_fifo_head_t fifo_i;
   mps_rf_wr_t rf_o;
   mps_flags_t flags_o;
   logic [7:0] ext_cc_i, io_dir_o;
   logic [11:0] pc_o, loop_count_o;
   logic [9:0] control_o, mode_o, got;
   logic [3:0] bus_addr_i;
   logic [15:0] bus_wdata_i, bus_rdata_o;
   int fails = 0;
   int checks_done = 0;
   mps_instr_t i;
   mps_row_t rows [7] = '{'{OP_CONTROL_SET, 10'h3ff, 2'd0, 10'h3ff}, '{OP_CONTROL_CLEAR, 10'h003, 2'd0, 10'h3fc},
      '{OP_CONTROL_CLEAR, 10'h3ff, 2'd0, 10'h000}, '{OP_SETIO, 10'h0ff, 2'd1, 10'h0ff},
      '{OP_IO_DIRECTION_CLEAR, 10'h00f, 2'd1, 10'h0f0}, '{OP_SETMODE, 10'h200, 2'd2, 10'h200},
      '{OP_MODE_CLEAR, 10'h200, 2'd2, 10'h000}};

   mps_seq_ctrl uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce_i), .ins_i(ins_i), .ext_cc_i(ext_cc_i),
      .pc_o(pc_o), .fifo_i(fifo_i), .fifo_pop_o(fifo_pop_o), .fifo_reset_o(fifo_reset_o), .rf_o(rf_o),
      .irq0_i(irq0_i), .irq7_i(irq7_i), .aco_evt_i(dor_evt_i), .bcz_evt_i(dor_evt_i), .dor_evt_i(dor_evt_i),
      .flags_o(flags_o), .stack_full_o(stack_full_o), .loop_count_o(loop_count_o), .control_o(control_o),
      .io_dir_o(io_dir_o), .mode_o(mode_o), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
      .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o));

   // ==========================================================
   // Helpers
   function automatic mps_instr_t mk(mps_op_t op, mps_cc_t cc, logic ht, logic [11:0] tg, logic [9:0] m);
      mps_instr_t r;
      r = '0;
      r.valid = 1'b1;
      r.op = op;
      r.cc = cc;
      r.has_target = ht;
      r.target = tg;
      r.mask = m;
      return r;
   endfunction

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic run(input mps_instr_t x);
      @(posedge clk_sys_i);
      ins_i <= x;
      @(posedge clk_sys_i);
      ins_i.valid <= 1'b0;
      #1;
   endtask

   task automatic rdf(input logic pop, input logic wr);
      @(posedge clk_sys_i);
      ins_i <= mk(OP_FIFO_TO_REGISTER_MOVE, CC_INTERRUPT_MODE, 1'b0, 12'h000, 10'h000);
      #1;
      chk(fifo_pop_o, pop);
      @(posedge clk_sys_i);
      ins_i.valid <= 1'b0;
      #1;
      chk(rf_o.wr, wr);
   endtask

   // Reads compare the data that stand in the cycle after the strobe
   task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      bus_wr_i <= wr;
      bus_rd_i <= !wr;
      bus_addr_i <= a;
      bus_wdata_i <= d;
      @(posedge clk_sys_i);
      bus_wr_i <= 1'b0;
      bus_rd_i <= 1'b0;
      #1;
      if (!wr) chk(bus_rdata_o, d);
   endtask

   task automatic pulse(input int n);
      @(posedge clk_sys_i);
      if (n == 0) irq0_i <= 1'b1; else if (n == 7) irq7_i <= 1'b1; else dor_evt_i <= 1'b1;
      @(posedge clk_sys_i);
      {irq0_i, irq7_i, dor_evt_i} <= 3'b000;
   endtask

   task automatic wrap_up;
      $display("checks_done=%0d fails=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // ==========================================================
   // Clock, watchdog and main sequence
   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end

   initial begin
      #200000;
      fails++;
      wrap_up;
   end

   initial begin
      {nrst_i, irq0_i, irq7_i, dor_evt_i, bus_wr_i, bus_rd_i} = '0;
      ce_i = 1'b1;
      ins_i = '0;
      ext_cc_i = 8'h00;
      fifo_i = '0;
      bus_addr_i = 4'h0;
      bus_wdata_i = 16'h0000;
      repeat (5) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      #1;
      chk(pc_o, 16'h0000);
      chk(control_o, MPS_CON_RST);
      foreach (rows[k]) begin
         run(mk(rows[k].op, CC_INTERRUPT_MODE, 1'b0, 12'h000, rows[k].mask));
         got = (rows[k].sel == 2'd0) ? control_o : (rows[k].sel == 2'd1) ? {2'b00, io_dir_o} : mode_o;
         chk(got, rows[k].exp);
         if (rows[k].sel == 2'd2) chk(fifo_reset_o, rows[k].exp[9]);
      end
      run(mk(OP_LDLC, CC_INTERRUPT_MODE, 1'b1, 12'h123, 10'h000));
      run(mk(OP_PUSH_LOOP_COUNT, CC_INTERRUPT_MODE, 1'b0, 12'h000, 10'h000));
      chk(loop_count_o, 16'h0123);
      run(mk(OP_LDLC, CC_INTERRUPT_MODE, 1'b1, 12'h045, 10'h000));
      run(mk(OP_POP_LOOP_COUNT, CC_INTERRUPT_MODE, 1'b0, 12'h000, 10'h000));
      chk(loop_count_o, 16'h0123);
      repeat (8) run(mk(OP_PUSH_LOOP_COUNT, CC_INTERRUPT_MODE, 1'b0, 12'h000, 10'h000));
      chk(stack_full_o, 1'b1);
      run(mk(OP_POP_LOOP_COUNT, CC_INTERRUPT_MODE, 1'b0, 12'h000, 10'h000));
      chk(stack_full_o, 1'b0);
      // Seven entries of 123h now on the stack
      ext_cc_i <= 8'h01;
      run(mk(OP_RC, CC_EXT0, 1'b0, 12'h000, 10'h000));
      chk(pc_o, 16'h0123);
      run(mk(OP_RC, CC_EXT0, 1'b1, 12'h200, 10'h000));
      chk(pc_o, 16'h0200);
      ext_cc_i <= 8'h00;
      run(mk(OP_RC, CC_EXT0, 1'b1, 12'h300, 10'h000));
      run(mk(OP_RNC, CC_EXT0, 1'b0, 12'h000, 10'h000));
      chk(pc_o, 16'h0123);
      ext_cc_i <= 8'h01;
      run(mk(OP_RNC, CC_EXT0, 1'b1, 12'h340, 10'h000));
      ext_cc_i <= 8'h00;
      run(mk(OP_RNC, CC_EXT0, 1'b1, 12'h350, 10'h000));
      chk(pc_o, 16'h0350);
      run(mk(OP_RET, CC_INTERRUPT_MODE, 1'b1, 12'h3a0, 10'h000));
      chk(pc_o, 16'h03a0);
      run(mk(OP_RET, CC_INTERRUPT_MODE, 1'b0, 12'h000, 10'h000));
      chk(pc_o, 16'h0123);
      repeat (7) run(mk(OP_PUSH_LOOP_COUNT, CC_INTERRUPT_MODE, 1'b0, 12'h000, 10'h000));
      chk(stack_full_o, 1'b0);
      run(mk(OP_PUSH_LOOP_COUNT, CC_INTERRUPT_MODE, 1'b0, 12'h000, 10'h000));
      chk(stack_full_o, 1'b1);
      fifo_i <= '{16'hbeef, 5'h03, 1'b0, 1'b0, 1'b0};
      rdf(1'b1, 1'b1);
      chk({rf_o.addr, rf_o.data[10:0]}, {5'h03, 11'h6ef});
      fifo_i <= '{16'h1111, 5'h07, 1'b0, 1'b1, 1'b0};
      rdf(1'b0, 1'b1);
      chk(rf_o.data, 16'hbeef);
      fifo_i <= '{16'h2222, 5'h09, 1'b1, 1'b0, 1'b0};
      rdf(1'b0, 1'b0);
      chk({flags_o.fifo_exception_flag, flags_o.fifo_input_flag}, 2'b11);
      pulse(1);
      run(mk(OP_RESTART, CC_INTERRUPT_MODE, 1'b0, 12'h000, 10'h000));
      chk(pc_o, 16'h0000);
      chk({stack_full_o, loop_count_o}, 16'h0123);
      chk({flags_o.data_out_flag, flags_o.address_counter_ones_flag, flags_o.block_count_zero_flag,
           flags_o.fifo_exception_flag, flags_o.carry}, 5'b00000);
      i = mk(OP_SBC, CC_INTERRUPT_MODE, 1'b0, 12'h000, 10'h000);
      i.src1 = 16'h0010;
      i.src2 = 16'h0003;
      run(i);
      chk(rf_o.data, 16'h000c);
      run(i);
      chk(rf_o.data, 16'h000d);
      // A count of one runs the body twice
      run(mk(OP_LDLC, CC_INTERRUPT_MODE, 1'b1, 12'h001, 10'h000));
      run(mk(OP_LOOP_END_BRANCH, CC_INTERRUPT_MODE, 1'b1, 12'h050, 10'h000));
      chk({pc_o, loop_count_o[3:0]}, 16'h0500);
      run(mk(OP_LOOP_END_BRANCH, CC_INTERRUPT_MODE, 1'b1, 12'h050, 10'h000));
      chk(pc_o, 16'h0051);
      run(mk(OP_SETMODE, CC_INTERRUPT_MODE, 1'b0, 12'h000, 10'h001));
      pulse(0);
      run(mk(OP_NOP, CC_INTERRUPT_MODE, 1'b0, 12'h000, 10'h000));
      chk(pc_o, MPS_VEC_INT0);
      pulse(7);
      run(mk(OP_NOP, CC_INTERRUPT_MODE, 1'b0, 12'h000, 10'h000));
      chk(pc_o, MPS_VEC_INT7);
      bus(1'b1, MPS_OFS_IO, 16'h005a);
      bus(1'b0, MPS_OFS_IO, 16'h005a);
      bus(1'b0, 4'h9, 16'h0000);
      bus(1'b1, MPS_OFS_CON, 16'h0003);
      run(mk(OP_CONTROL_CLEAR, CC_INTERRUPT_MODE, 1'b0, 12'h000, 10'h001));
      bus(1'b0, MPS_OFS_CON, 16'h0002);
      // Enable low must keep the fifo reset bit frozen
      run(mk(OP_SETMODE, CC_INTERRUPT_MODE, 1'b0, 12'h000, 10'h200));
      ce_i <= 1'b0;
      run(mk(OP_MODE_CLEAR, CC_INTERRUPT_MODE, 1'b0, 12'h000, 10'h200));
      chk(fifo_reset_o, 1'b1);
      ce_i <= 1'b1;
      run(mk(OP_MODE_CLEAR, CC_INTERRUPT_MODE, 1'b0, 12'h000, 10'h200));
      chk({fifo_reset_o, mode_o}, 16'h0001);
      wrap_up;
   end
endmodule
`default_nettype wire
